// >>> verilog/adc_seq_pkg.sv
// Constants, register map and state codes of the conversion sequencer
package adc_seq_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int CHAN_W = 4;
  localparam int SRC_W = 4;
  localparam int DIV_SEL_W = 3;
  localparam int REF_W = 2;
  localparam int SAMPLE_CYCLES = 4;
  localparam int CONVERT_CYCLES = 12;
  localparam int TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;
  localparam logic [RES_W-1:0] FULL_SCALE = 12'hfff;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RES_LO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h6;
  // Field positions
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int POWER_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int SRC_LSB = 4;
  localparam int DIV_LSB = 0;
  localparam int FMT_BIT = 4;
  localparam int REF_LSB = 0;
  localparam int GIE_BIT = 7;
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_W = 2;
  // Reference code that routes the amplifier output to the reference
  localparam logic [REF_W-1:0] REF_PGA = 2'h1;
  // Values after reset
  localparam logic [DATA_W-1:0] CTRL0_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTRL1_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTRL2_RST = 8'h00;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_type;
endpackage

// >>> verilog/conv_div_if.sv
// Link between the sequencer and its converter clock divider
`timescale 1ns/1ns
interface conv_div_if;
  logic [adc_seq_pkg::DIV_SEL_W-1:0] sel;
  logic clear;
  logic tick;
  modport ctrl (output sel, output clear, input tick);
  modport div (input sel, input clear, output tick);
endinterface

// >>> verilog/conv_clk_div.sv
// Power-of-two converter clock divider producing one tick per period
`timescale 1ns/1ns
module conv_clk_div
#(
  parameter int SEL_W = 3
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  conv_div_if.div dv
);
  localparam int CNT_W = (1 << SEL_W) - 1;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] limit;

  // Wider selects would need a counter wider than the logic is sized for
  if (SEL_W < 1 || SEL_W > 4)
  begin : g_bad_sel
    $error("conv_clk_div: SEL_W out of range");
  end

  // Period is 2**sel system clocks, 000 undivided up to 111 by 128
  always_comb
  begin
    limit = CNT_W'((CNT_W+1)'(1) << dv.sel) - CNT_W'(1);
    dv.tick = !dv.clear && (cnt_r == limit);
    cnt_nxt = cnt_r + CNT_W'(1);
    if (dv.clear || dv.tick)
      cnt_nxt = '0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  chk_tick_spacing: assert property (
    (dv.tick && dv.sel == 3'h1) ##1 (!dv.clear && $stable(dv.sel))
    |-> !dv.tick ##1 (dv.clear || dv.tick))
    else $error("divide-by-two tick spacing wrong");
  chk_count_bound: assert property (
    cnt_r <= limit || $changed(dv.sel) || dv.clear)
    else $error("divider count passed its limit");
endmodule // conv_clk_div

// >>> verilog/adc_conversion_sequencer.sv
// Sequencer, registers and interrupt of the 12-bit SAR converter
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module adc_conversion_sequencer
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [adc_seq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [adc_seq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [adc_seq_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_cmp_hi,
  output logic o_irq,
  output logic o_busy,
  output logic o_sar_power_on,
  output logic o_sample_en,
  output logic [adc_seq_pkg::RES_W-1:0] o_sar_trial,
  output logic o_ext_connect,
  output logic [adc_seq_pkg::CHAN_W-1:0] o_ext_channel,
  output logic o_int_connect,
  output logic [adc_seq_pkg::SRC_W-2:0] o_int_source,
  output logic o_gnd_connect,
  output logic [adc_seq_pkg::REF_W-1:0] o_ref_sel,
  output logic o_ref_from_pga
);
  import adc_seq_pkg::*;

  conv_div_if dvi ();

  logic start_r;
  logic start_nxt;
  logic start_d_r;
  logic power_r;
  logic power_nxt;
  logic [CHAN_W-1:0] chan_r;
  logic [CHAN_W-1:0] chan_nxt;
  logic [SRC_W-1:0] src_r;
  logic [SRC_W-1:0] src_nxt;
  logic [DIV_SEL_W-1:0] div_r;
  logic [DIV_SEL_W-1:0] div_nxt;
  logic fmt_r;
  logic fmt_nxt;
  logic [REF_W-1:0] ref_r;
  logic [REF_W-1:0] ref_nxt;
  logic gie_r;
  logic gie_nxt;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] mask_nxt;
  conv_state_type state_r;
  conv_state_type state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [RES_W-1:0] sar_r;
  logic [RES_W-1:0] sar_nxt;
  logic [RES_W-1:0] bit_r;
  logic [RES_W-1:0] bit_nxt;
  logic [RES_W-1:0] res_r;
  logic [RES_W-1:0] res_nxt;
  logic [RES_W-1:0] decided;
  logic start_fall;
  logic done_ev;
  logic abort_ev;
  logic [EV_W-1:0] stat_r;
  logic [EV_W-1:0] stat_nxt;
  logic [EV_W-1:0] events;
  logic [15:0] res_left;
  logic [15:0] res_right;
  logic [DATA_W-1:0] res_hi;
  logic [DATA_W-1:0] res_lo;
  logic [DATA_W-1:0] rdata_nxt;
  logic ext_sel;
  logic int_sel;
  logic [4:0] ticks_h;

  conv_clk_div #(
    .SEL_W(DIV_SEL_W)
  ) u_div (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .dv(dvi.div)
  );

  // Software register writes; the write port never waits
  always_comb
  begin
    start_nxt = start_r;
    power_nxt = power_r;
    chan_nxt = chan_r;
    src_nxt = src_r;
    div_nxt = div_r;
    fmt_nxt = fmt_r;
    ref_nxt = ref_r;
    gie_nxt = gie_r;
    mask_nxt = mask_r;
    if (i_wr)
    begin
      case (i_addr)
        ADDR_CTRL0:
        begin
          start_nxt = i_wdata[START_BIT];
          power_nxt = i_wdata[POWER_BIT];
          chan_nxt = i_wdata[CHAN_LSB +: CHAN_W];
        end
        ADDR_CTRL1:
        begin
          src_nxt = i_wdata[SRC_LSB +: SRC_W];
          div_nxt = i_wdata[DIV_LSB +: DIV_SEL_W];
        end
        ADDR_CTRL2:
        begin
          fmt_nxt = i_wdata[FMT_BIT];
          ref_nxt = i_wdata[REF_LSB +: REF_W];
          gie_nxt = i_wdata[GIE_BIT];
        end
        ADDR_IRQ_MASK:
          mask_nxt = i_wdata[EV_W-1:0];
        default:
          mask_nxt = mask_r;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      start_r <= CTRL0_RST[START_BIT];
      start_d_r <= CTRL0_RST[START_BIT];
      power_r <= CTRL0_RST[POWER_BIT];
      chan_r <= CTRL0_RST[CHAN_LSB +: CHAN_W];
      src_r <= CTRL1_RST[SRC_LSB +: SRC_W];
      div_r <= CTRL1_RST[DIV_LSB +: DIV_SEL_W];
      fmt_r <= CTRL2_RST[FMT_BIT];
      ref_r <= CTRL2_RST[REF_LSB +: REF_W];
      gie_r <= CTRL2_RST[GIE_BIT];
      mask_r <= IRQ_MASK_RST;
    end
    else
    begin
      start_r <= start_nxt;
      start_d_r <= start_r;
      power_r <= power_nxt;
      chan_r <= chan_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      fmt_r <= fmt_nxt;
      ref_r <= ref_nxt;
      gie_r <= gie_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Divider restarts with each conversion so the first tick is a full period
  assign dvi.sel = div_r;
  assign dvi.clear = (state_r == ST_IDLE) || start_r || !power_r;
  assign start_fall = start_d_r && !start_r && power_r;

  // Sequencer with one SAR decision per converter clock, MSB first
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sar_nxt = sar_r;
    bit_nxt = bit_r;
    res_nxt = res_r;
    done_ev = 1'b0;
    abort_ev = 1'b0;
    decided = i_cmp_hi ? sar_r : (sar_r & ~bit_r);
    if (!power_r || start_r)
    begin
      // Held in reset while start is high or power is off
      abort_ev = (state_r != ST_IDLE);
      state_nxt = ST_IDLE;
      cnt_nxt = '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (start_fall)
          begin
            state_nxt = ST_SAMPLE;
            cnt_nxt = '0;
          end
        ST_SAMPLE:
          if (dvi.tick)
          begin
            if (cnt_r == 4'(SAMPLE_CYCLES - 1))
            begin
              state_nxt = ST_CONVERT;
              cnt_nxt = '0;
              bit_nxt = {1'b1, {(RES_W-1){1'b0}}};
              sar_nxt = {1'b1, {(RES_W-1){1'b0}}};
            end
            else
              cnt_nxt = cnt_r + 4'h1;
          end
        ST_CONVERT:
          if (dvi.tick)
          begin
            bit_nxt = bit_r >> 1;
            sar_nxt = decided | (bit_r >> 1);
            if (cnt_r == 4'(CONVERT_CYCLES - 1))
            begin
              state_nxt = ST_IDLE;
              res_nxt = decided;
              done_ev = 1'b1;
            end
            else
              cnt_nxt = cnt_r + 4'h1;
          end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      sar_r <= RESULT_RST;
      bit_r <= RESULT_RST;
      res_r <= RESULT_RST;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sar_r <= sar_nxt;
      bit_r <= bit_nxt;
      res_r <= res_nxt;
    end
  end

  // Sticky events, write one to clear; a same-cycle event wins the clear
  assign events = {abort_ev, done_ev};
  always_comb
  begin
    stat_nxt = stat_r;
    if (i_wr && i_addr == ADDR_IRQ_STAT)
      stat_nxt = stat_r & ~i_wdata[EV_W-1:0];
    stat_nxt = stat_nxt | events;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      stat_r <= '0;
    else
      stat_r <= stat_nxt;
  end

  assign o_irq = gie_r && |(stat_r & mask_r);

  // Result layout: left justified when the format bit is low
  assign res_left = {res_r, {(16-RES_W){1'b0}}};
  assign res_right = 16'(res_r);
  assign res_hi = fmt_r ? res_right[15:8] : res_left[15:8];
  assign res_lo = fmt_r ? res_right[7:0] : res_left[7:0];

  // Read data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_nxt = '0;
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CTRL0:
        begin
          rdata_nxt[START_BIT] = start_r;
          rdata_nxt[BUSY_BIT] = o_busy;
          rdata_nxt[POWER_BIT] = power_r;
          rdata_nxt[CHAN_LSB +: CHAN_W] = chan_r;
        end
        ADDR_CTRL1:
        begin
          rdata_nxt[SRC_LSB +: SRC_W] = src_r;
          rdata_nxt[DIV_LSB +: DIV_SEL_W] = div_r;
        end
        ADDR_CTRL2:
        begin
          rdata_nxt[FMT_BIT] = fmt_r;
          rdata_nxt[REF_LSB +: REF_W] = ref_r;
          rdata_nxt[GIE_BIT] = gie_r;
        end
        ADDR_RES_HI:
          rdata_nxt = res_hi;
        ADDR_RES_LO:
          rdata_nxt = res_lo;
        ADDR_IRQ_STAT:
          rdata_nxt[EV_W-1:0] = stat_r;
        ADDR_IRQ_MASK:
          rdata_nxt[EV_W-1:0] = mask_r;
        default:
          rdata_nxt = '0;
      endcase
    end
  end

  // Source decode: 10xx grounds the converter input
  assign ext_sel = (src_r == 4'h0) || (src_r == 4'h4) || (src_r[3:2] == 2'h3);
  assign int_sel = !src_r[3] && (src_r[1:0] != 2'h0);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= '0;
      o_ext_connect <= 1'b0;
      o_int_connect <= 1'b0;
      o_gnd_connect <= 1'b0;
      o_ext_channel <= '0;
      o_int_source <= '0;
      o_ref_sel <= '0;
      o_ref_from_pga <= 1'b0;
    end
    else
    begin
      o_rdata <= rdata_nxt;
      o_ext_connect <= ext_sel && !int_sel;
      o_int_connect <= int_sel;
      o_gnd_connect <= !ext_sel && !int_sel;
      o_ext_channel <= chan_r;
      o_int_source <= src_r[2:0];
      o_ref_sel <= ref_r;
      o_ref_from_pga <= (ref_r == REF_PGA);
    end
  end

  assign o_busy = (state_r != ST_IDLE);
  assign o_sar_power_on = power_r;
  assign o_sample_en = (state_r == ST_SAMPLE);
  assign o_sar_trial = sar_r;

  // Converter ticks since the conversion began, read by the checks only
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || state_r == ST_IDLE)
      ticks_h <= '0;
    else if (dvi.tick)
      ticks_h <= ticks_h + 5'h1;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  chk_sample_len: assert property (
    $rose(state_r == ST_CONVERT) |-> ticks_h == 5'(SAMPLE_CYCLES))
    else $error("sampling phase length wrong");
  chk_total_len: assert property (
    done_ev |-> ticks_h == 5'(TOTAL_CYCLES - 1) && dvi.tick)
    else $error("conversion did not take 16 converter clocks");
  chk_start_pulse: assert property (
    (state_r == ST_IDLE && start_r && power_r) ##1 (!start_r && power_r)
    |=> o_busy && o_sample_en)
    else $error("start pulse did not begin a conversion");
  chk_held_reset: assert property (
    start_r |=> !o_busy)
    else $error("converter ran while start held high");
  // Sampling may last 512 clocks, so busy is held step by step instead
  chk_busy_span: assert property (
    (o_busy && !done_ev && !abort_ev) |=> o_busy)
    else $error("busy dropped before completion");
  chk_done_result: assert property (
    done_ev |=> !o_busy && res_r == $past(decided) && stat_r[EV_DONE])
    else $error("completion did not clear busy and load result");
  chk_result_hold: assert property (
    !done_ev |=> $stable(res_r))
    else $error("result changed without completion");
  chk_power_off: assert property (
    !power_r |-> !o_sar_power_on ##1 !o_busy)
    else $error("converter active while disabled");
  chk_ext_disc: assert property (
    int_sel |=> o_int_connect && !o_ext_connect)
    else $error("external input still connected");
  chk_irq_raise: assert property (
    (done_ev && gie_r && mask_r[EV_DONE] && !i_wr) |=> o_irq)
    else $error("completion failed to raise interrupt");
  chk_format_right: assert property (
    (i_rd && i_addr == ADDR_RES_HI && fmt_r) |=> o_rdata[7:4] == 4'h0)
    else $error("right justified high byte not padded");

  cov_full_conv: cover property (start_fall ##[1:300] done_ev);
  cov_abort: cover property (abort_ev);
  cov_irq: cover property ($rose(o_irq));
  cov_full_scale: cover property (done_ev && decided == FULL_SCALE);
endmodule // adc_conversion_sequencer

// >>> tb/test_adc_conversion_sequencer.sv
// Self-checking testbench of the conversion sequencer
`timescale 1ns/1ns
module test_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  typedef struct {
    logic [SRC_W-1:0] src;
    logic [REF_W-1:0] refsel;
    logic ext;
    logic intl;
    logic gnd;
    logic pga;
  } row_type;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [ADDR_W-1:0] i_addr = 3'h0;
  logic [DATA_W-1:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cmp_hi = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic o_irq, o_busy, o_sar_power_on, o_sample_en;
  logic [RES_W-1:0] o_sar_trial;
  logic o_ext_connect, o_int_connect, o_gnd_connect, o_ref_from_pga;
  logic [CHAN_W-1:0] o_ext_channel;
  logic [SRC_W-2:0] o_int_source;
  logic [REF_W-1:0] o_ref_sel;
  int err_total = 0;
  int checks = 0;
  int n_busy;
  int n_samp;
  row_type rows [16];
  logic [DATA_W-1:0] rd_val;
  logic [RES_W-1:0] res;
  logic fmt;

  always #50 i_ref_clk = ~i_ref_clk;

  adc_conversion_sequencer i_dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmp_hi(i_cmp_hi), .o_irq(o_irq), .o_busy(o_busy),
    .o_sar_power_on(o_sar_power_on), .o_sample_en(o_sample_en),
    .o_sar_trial(o_sar_trial), .o_ext_connect(o_ext_connect),
    .o_ext_channel(o_ext_channel), .o_int_connect(o_int_connect),
    .o_int_source(o_int_source), .o_gnd_connect(o_gnd_connect),
    .o_ref_sel(o_ref_sel), .o_ref_from_pga(o_ref_from_pga)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
    chk({8'h0, rd_val}, {8'h0, e});
  endtask

  // Bounded so that a stuck busy cannot hang the run
  task automatic count_busy;
    n_busy = 0;
    n_samp = 0;
    @(posedge i_ref_clk);
    #1;
    while (o_busy === 1'b1 && n_busy < 3000)
    begin
      n_busy++;
      if (o_sample_en === 1'b1)
        n_samp++;
      @(posedge i_ref_clk);
      #1;
    end
  endtask

  task automatic close_out;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    err_total++;
    close_out();
  end

  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      rows[i].src = i[3:0];
      rows[i].refsel = i[1:0];
      rows[i].ext = (i == 0) || (i == 4) || (i[3:2] == 2'b11);
      rows[i].intl = !i[3] && (i[1:0] != 2'b00);
      rows[i].gnd = (i[3:2] == 2'b10);
      rows[i].pga = (i[1:0] == REF_PGA);
    end
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    for (int a = 0; a < 8; a++)
      rchk(a[2:0], 8'h00);
    @(posedge i_ref_clk);
    #1;
    chk({8'h0, o_rdata}, 16'h0);
    chk1(o_busy, 1'b0);
    chk1(o_sar_power_on, 1'b0);
    chk1(o_ext_connect, 1'b1);
    wr(ADDR_RES_HI, 8'hff);
    wr(3'h7, 8'hff);
    rchk(ADDR_RES_HI, 8'h00);
    rchk(3'h7, 8'h00);
    // Source and reference selection table
    for (int i = 0; i < 16; i++)
    begin
      wr(ADDR_CTRL0, {4'h0, ~rows[i].src});
      wr(ADDR_CTRL1, {rows[i].src, 4'h0});
      wr(ADDR_CTRL2, {6'h0, rows[i].refsel});
      @(posedge i_ref_clk);
      #1;
      chk1(o_ext_connect, rows[i].ext);
      chk1(o_int_connect, rows[i].intl);
      chk1(o_gnd_connect, rows[i].gnd);
      chk({13'h0, o_int_source}, {13'h0, rows[i].src[2:0]});
      chk({12'h0, o_ext_channel}, {12'h0, ~rows[i].src});
      chk({14'h0, o_ref_sel}, {14'h0, rows[i].refsel});
      chk1(o_ref_from_pga, rows[i].pga);
    end
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL2, 8'h00);
    // Start pulse with the converter powered down
    wr(ADDR_CTRL0, 8'h80);
    wr(ADDR_CTRL0, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk1(o_busy, 1'b0);
    chk1(o_sar_power_on, 1'b0);
    // Start held high keeps the converter idle
    wr(ADDR_CTRL0, 8'ha0);
    repeat (4) @(posedge i_ref_clk);
    #1;
    chk1(o_sar_power_on, 1'b1);
    chk1(o_busy, 1'b0);
    wr(ADDR_CTRL0, 8'h20);
    count_busy();
    chk(16'(n_busy), 16'd16);
    wr(ADDR_IRQ_STAT, 8'h01);
    // Every divider code, alternating result and format
    for (int s = 0; s < 8; s++)
    begin
      fmt = s[1];
      res = s[0] ? FULL_SCALE : 12'h000;
      wr(ADDR_CTRL2, {3'h0, fmt, 4'h0});
      wr(ADDR_CTRL1, {5'h0, s[2:0]});
      @(posedge i_ref_clk);
      i_cmp_hi <= s[0];
      wr(ADDR_CTRL0, 8'ha0);
      wr(ADDR_CTRL0, 8'h20);
      count_busy();
      chk(16'(n_busy), 16'(TOTAL_CYCLES << s));
      chk(16'(n_samp), 16'(SAMPLE_CYCLES << s));
      rchk(ADDR_RES_HI, fmt ? {4'h0, res[11:8]} : res[11:4]);
      rchk(ADDR_RES_LO, fmt ? res[7:0] : {res[3:0], 4'h0});
      rchk(ADDR_IRQ_STAT, 8'h01);
      chk1(o_irq, 1'b0);
      wr(ADDR_IRQ_STAT, 8'h01);
    end
    // Interrupt enabled, then masked, then unmasked late
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL2, 8'h80);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CTRL0, 8'ha0);
    wr(ADDR_CTRL0, 8'h20);
    count_busy();
    chk1(o_irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h01);
    @(posedge i_ref_clk);
    #1;
    chk1(o_irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_CTRL0, 8'ha0);
    wr(ADDR_CTRL0, 8'h20);
    count_busy();
    chk1(o_irq, 1'b0);
    rchk(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    @(posedge i_ref_clk);
    #1;
    chk1(o_irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_CTRL2, 8'h00);
    // Abort by a second start mid-conversion; result must survive
    @(posedge i_ref_clk);
    i_cmp_hi <= 1'b0;
    wr(ADDR_CTRL0, 8'ha0);
    wr(ADDR_CTRL0, 8'h20);
    rchk(ADDR_CTRL0, 8'h60);
    rchk(ADDR_CTRL1, 8'h00);
    @(posedge i_ref_clk);
    #1;
    chk({4'h0, o_sar_trial}, 16'h0800);
    wr(ADDR_CTRL0, 8'ha0);
    @(posedge i_ref_clk);
    #1;
    chk1(o_busy, 1'b0);
    rchk(ADDR_IRQ_STAT, 8'h02);
    rchk(ADDR_RES_HI, 8'hff);
    wr(ADDR_CTRL0, 8'h20);
    count_busy();
    chk(16'(n_busy), 16'd16);
    rchk(ADDR_RES_HI, 8'h00);
    // Mid-conversion reset drops busy and clears CTRL0 and the interrupt status
    @(posedge i_ref_clk);
    i_cmp_hi <= 1'b1;
    wr(ADDR_CTRL0, 8'ha0);
    wr(ADDR_CTRL0, 8'h20);
    repeat (6) @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk1(o_busy, 1'b0);
    chk1(o_sar_power_on, 1'b0);
    rchk(ADDR_CTRL0, 8'h00);
    rchk(ADDR_IRQ_STAT, 8'h00);
    close_out();
  end
endmodule // test_adc_conversion_sequencer
